// ---- hplsm_params.svh ----
// constants shared by the host port and the line serial master
// assumes inclusion by bare name from the link and host port modules
`ifndef HPLSM_PARAMS_SVH
`define HPLSM_PARAMS_SVH
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define HPLSM_ADDR_SER_DATA 12'h023
`define HPLSM_ADDR_SER_ADDR 12'h024
`define HPLSM_ADDR_SER_CFG 12'h025
`define HPLSM_CFG_SEL_A 0
`define HPLSM_CFG_SEL_B 1
`define HPLSM_CFG_FAST 2
`define HPLSM_CFG_TICK_OUT 3
`define HPLSM_CFG_RESET 4'h0
`define HPLSM_SER_BITS 16
// ----------------------------------------
// timing
// ----------------------------------------
`define HPLSM_MCLK_MHZ 100
`define HPLSM_ONE_SEC_US 1000000
`define HPLSM_LINK_KHZ 166666
`define HPLSM_SER_SLOW_KHZ 1024
`define HPLSM_SER_FAST_KHZ 8192
`endif

// ---- hplsm_pkg.sv ----
// types shared by the host port and the line serial master
// assumes nothing beyond the constants header
`default_nettype none
package hplsm_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } hplsm_ser_word_t;
  typedef struct packed {
    logic fast;
    logic sel_b;
    logic sel_a;
  } hplsm_ser_cfg_t;
  typedef enum logic {ST_IDLE, ST_SHIFT} hplsm_ser_st_t;
endpackage : hplsm_pkg
`default_nettype wire

// ---- hplsm_ser_link.sv ----
// line serial master engine, runs on the link reference clock
// assumes word and cfg stay steady while a transfer runs
`default_nettype none
`include "hplsm_params.svh"
module hplsm_ser_link import hplsm_pkg::*; #(
  parameter int HALF_FAST = 10,
  parameter int HALF_SLOW = 81
) (
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic start_tgl_i,
  input wire hplsm_ser_cfg_t cfg_i,
  input wire hplsm_ser_word_t word_i,
  output logic done_tgl_o,
  output logic [7:0] rx_o,
  input wire logic ser_in_i,
  output logic ser_clk_o,
  output logic ser_out_o,
  output logic [1:0] sel_n_o
);
  localparam int DW = $clog2(HALF_SLOW + 1);
  // ----------------------------------------
  // crossings into the link domain
  // ----------------------------------------
  logic [2:0] start_q;
  hplsm_ser_cfg_t cfg_m_q, cfg_s_q;
  logic din_m_q, din_s_q;
  hplsm_ser_st_t st_q;
  logic [DW-1:0] div_q;
  logic [4:0] bits_q;
  logic [15:0] sh_q;
  logic [7:0] rx_sh_q;
  logic [1:0] sel_q;
  wire logic start_ev = start_q[2] ^ start_q[1];
  wire logic [DW-1:0] half = cfg_s_q.fast ? DW'(HALF_FAST) : DW'(HALF_SLOW); // R12
  wire logic div_done = (div_q == half - DW'(1));
  wire logic last_bit = (bits_q == 5'(`HPLSM_SER_BITS - 1));
  assign sel_n_o = ~sel_q; // R15
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= 3'h0;
      cfg_m_q <= '0;
      cfg_s_q <= '0;
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end else begin
      start_q <= {start_q[1:0], start_tgl_i};
      cfg_m_q <= cfg_i;
      cfg_s_q <= cfg_m_q;
      din_m_q <= ser_in_i;
      din_s_q <= din_m_q;
    end
  end
  // ----------------------------------------
  // shifter
  // ----------------------------------------
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      div_q <= '0;
      bits_q <= 5'h0;
      sh_q <= 16'h0;
      rx_sh_q <= 8'h0;
      rx_o <= 8'h0;
      sel_q <= 2'h0;
      ser_clk_o <= 1'b0;
      ser_out_o <= 1'b0;
      done_tgl_o <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          ser_clk_o <= 1'b0; // R11
          div_q <= '0;
          if (start_ev) begin
            st_q <= ST_SHIFT;
            sh_q <= word_i; // R13
            ser_out_o <= word_i.addr[7];
            bits_q <= 5'h0;
            sel_q <= {cfg_s_q.sel_b, cfg_s_q.sel_a}; // R16
          end
        end
        ST_SHIFT: begin
          div_q <= div_done ? '0 : div_q + DW'(1);
          if (div_done) begin
            ser_clk_o <= ~ser_clk_o; // R11
            if (!ser_clk_o) begin
              rx_sh_q <= {rx_sh_q[6:0], din_s_q}; // R10
            end else if (last_bit) begin
              // select held over the whole frame, dropped after last bit
              st_q <= ST_IDLE;
              sel_q <= 2'h0; // R21
              rx_o <= rx_sh_q; // R10
              done_tgl_o <= ~done_tgl_o;
            end else begin
              bits_q <= bits_q + 5'h1;
              sh_q <= {sh_q[14:0], 1'b0};
              ser_out_o <= sh_q[14]; // R14
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge link_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_out_on_fall: assert property ( // R14
    st_q == ST_SHIFT && $past(st_q) == ST_SHIFT && $changed(ser_out_o) |-> $fell(ser_clk_o))
    else $error("serial out changed away from falling clock");
  a_idle_clock_low: assert property (st_q == ST_IDLE |-> !ser_clk_o) // R11
    else $error("serial clock runs while idle");
  // a start seen in idle loads the selects at that same edge, so it is excluded
  a_select_release: assert property (st_q == ST_IDLE && !start_ev |=> &sel_n_o) // R21
    else $error("serial select left asserted after frame");
  a_rx_on_rise: assert property ($rose(ser_clk_o) |-> rx_sh_q[0] == $past(din_s_q)) // R10
    else $error("serial input not taken at rising clock");
endmodule : hplsm_ser_link
`default_nettype wire

// ---- hplsm_host_port.sv ----
// host parallel port glue, group pins and line serial master control
// assumes host pins are asynchronous to MCLK_I; framer regs sit outside
// How it works
// R1 - select high ends access, floats data bus
// R2 - strobe is read strobe or data strobe
// R3 - direction pin is write strobe or direction
// R4 - input tick pin realigns the second timer
// R5 - output tick pin rises at each second
// R6 - irq pulled low while requests pending
// R7 - irq released once all requests serviced
// R8 - ack low while addr strobe and select low
// R9 - irq, ack, tick duplicated per framer group
// R10 - serial input sampled rising, into data register
// R11 - device generates the serial bit clock
// R12 - serial clock is one of two rates
// R13 - address and data shifted out serially
// R14 - serial output changes on falling edge only
// R15 - serial select driven from config register
// R16 - two independent serial selects
// R17 - bus style picks separate or muxed address
// R18 - address latched on address strobe fall
// R19 - strobes sampled on host clock rising edges; no host clock pin, sampled on MCLK_I rising edges
// R20 - host holds reset at least two clocks
// R21 - serial select held across whole transfer
// R22 - tick pin direction from software, input default
`default_nettype none
`include "hplsm_params.svh"
module hplsm_host_port import hplsm_pkg::*; #(
  parameter int NGRP = 2,
  parameter int SEC_CYCLES = `HPLSM_ONE_SEC_US * `HPLSM_MCLK_MHZ,
  parameter int SER_HALF_FAST = `HPLSM_LINK_KHZ / (2 * `HPLSM_SER_FAST_KHZ),
  parameter int SER_HALF_SLOW = `HPLSM_LINK_KHZ / (2 * `HPLSM_SER_SLOW_KHZ)
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic LINK_CLK_I,
  input wire logic BUS_STYLE_SELECT_I,
  input wire logic SYNC_BUS_SELECT_I,
  input wire logic [NGRP-1:0] HOST_SELECT_N_I,
  input wire logic HOST_ADDR_LATCH_N_I,
  input wire logic HOST_STROBE_N_I,
  input wire logic HOST_DIR_I,
  input wire logic [11:0] HOST_ADDR_I,
  input wire logic [7:0] HOST_AD_I,
  output logic [7:0] HOST_AD_O,
  output logic HOST_AD_OE_N_O,
  output logic [11:0] REG_ADDR_O,
  output logic [7:0] REG_WDATA_O,
  output logic REG_WR_O,
  input wire logic [7:0] REG_RDATA_I,
  input wire logic [NGRP-1:0] IRQ_PENDING_I,
  output logic [NGRP-1:0] IRQ_N_O,
  output logic [NGRP-1:0] IRQ_OE_N_O,
  output logic [NGRP-1:0] XFER_ACK_N_O,
  output logic [NGRP-1:0] XFER_ACK_OE_N_O,
  input wire logic [NGRP-1:0] SECOND_TICK_I,
  output logic [NGRP-1:0] SECOND_TICK_O,
  output logic [NGRP-1:0] SECOND_TICK_OE_N_O,
  output logic [NGRP-1:0] STATUS_TICK_O,
  input wire logic LINE_SER_IN_I,
  output logic LINE_SER_CLK_O,
  output logic LINE_SER_OUT_O,
  output logic [1:0] LINE_SER_SELECT_N_O
);
  localparam int SW = 2 * NGRP + 25;
  localparam int CW = $clog2(SEC_CYCLES + 1);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // every host pin passes two flops; this costs about two MCLK cycles
  // of strobe latency but keeps metastability out of the decode
  wire logic [SW-1:0] pin_raw = {SECOND_TICK_I, HOST_SELECT_N_I, HOST_ADDR_LATCH_N_I,
    HOST_STROBE_N_I, HOST_DIR_I, BUS_STYLE_SELECT_I, SYNC_BUS_SELECT_I,
    HOST_ADDR_I, HOST_AD_I};
  logic [SW-1:0] meta_q, pin_q;
  wire logic [NGRP-1:0] tick_s;
  wire logic [NGRP-1:0] cs_s;
  wire logic as_s;
  wire logic strobe_s;
  wire logic dir_s;
  wire logic style_s;
  wire logic syncm_s;
  wire logic [11:0] a_s;
  wire logic [7:0] ad_s;
  assign {tick_s, cs_s, as_s, strobe_s, dir_s, style_s, syncm_s, a_s, ad_s} = pin_q;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // strobes and selects idle high so no access is seen at release
      meta_q <= {{NGRP{1'b0}}, {(NGRP + 3){1'b1}}, 22'h0};
      pin_q <= {{NGRP{1'b0}}, {(NGRP + 3){1'b1}}, 22'h0};
    end else begin
      meta_q <= pin_raw; // R19
      pin_q <= meta_q; // R19
    end
  end
  // ----------------------------------------
  // strobe decode
  // ----------------------------------------
  wire logic cs_any = ~&cs_s; // R1
  wire logic rd_act = cs_any & (style_s ? ~strobe_s : (~strobe_s & dir_s)); // R2
  wire logic wr_act = cs_any & (style_s ? ~dir_s : (~strobe_s & ~dir_s)); // R3
  wire logic [11:0] addr_mux = style_s ? {a_s[11:8], ad_s} : a_s; // R17
  logic as_d1_q;
  logic rd_act_q;
  logic wr_act_q;
  logic [11:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  wire logic as_fell = as_d1_q & ~as_s; // R18
  // commit on strobe release so the byte used is the last one sampled
  // while the strobe was active; a write sampled active for one clock is still taken
  wire logic commit = wr_act_q & ~wr_act;
  // ----------------------------------------
  // local registers
  // ----------------------------------------
  logic [3:0] cfg_q;
  logic busy_q;
  logic start_tgl_q;
  hplsm_ser_word_t word_q;
  logic [7:0] rx_q;
  logic [2:0] done_q;
  wire logic [7:0] link_rx;
  wire logic link_done_tgl;
  wire logic done_ev = done_q[2] ^ done_q[1];
  wire logic hit_data = (addr_q == `HPLSM_ADDR_SER_DATA);
  wire logic hit_addr = (addr_q == `HPLSM_ADDR_SER_ADDR);
  wire logic hit_cfg = (addr_q == `HPLSM_ADDR_SER_CFG);
  wire logic hit_loc = hit_data | hit_addr | hit_cfg;
  wire logic [7:0] cfg_rd = {busy_q, 3'h0, cfg_q};
  wire logic [7:0] rd_mux = hit_data ? rx_q : hit_addr ? word_q.addr :
    hit_cfg ? cfg_rd : REG_RDATA_I;
  wire logic tick_out = cfg_q[`HPLSM_CFG_TICK_OUT]; // R22
  wire hplsm_ser_cfg_t ser_cfg = '{fast: cfg_q[`HPLSM_CFG_FAST],
    sel_b: cfg_q[`HPLSM_CFG_SEL_B], sel_a: cfg_q[`HPLSM_CFG_SEL_A]}; // R15
  assign HOST_AD_O = rdata_q;
  assign HOST_AD_OE_N_O = ~rd_act_q; // R1
  assign REG_ADDR_O = addr_q;
  assign REG_WDATA_O = wdata_q;
  assign REG_WR_O = commit & ~hit_loc;
  assign IRQ_N_O = '0;
  assign XFER_ACK_N_O = '0;
  assign SECOND_TICK_OE_N_O = {NGRP{~tick_out}}; // R22
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      as_d1_q <= 1'b1;
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      addr_q <= 12'h000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      as_d1_q <= as_s;
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (as_fell) begin
        addr_q <= addr_mux; // R18
      end
      if (wr_act) begin
        wdata_q <= ad_s;
      end
      if (rd_act && !rd_act_q) begin
        rdata_q <= rd_mux;
      end
    end
  end
  // writes to the serial word are ignored while a frame is running
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cfg_q <= `HPLSM_CFG_RESET; // R20
      busy_q <= 1'b0;
      start_tgl_q <= 1'b0;
      word_q <= '0;
      rx_q <= 8'h00;
      done_q <= 3'h0;
    end else begin
      done_q <= {done_q[1:0], link_done_tgl};
      if (commit && hit_cfg) begin
        cfg_q <= wdata_q[3:0]; // R15
      end
      if (commit && hit_data && !busy_q) begin
        word_q.data <= wdata_q;
      end
      if (commit && hit_addr && !busy_q) begin
        word_q.addr <= wdata_q; // R13
        start_tgl_q <= ~start_tgl_q;
        busy_q <= 1'b1;
      end else if (done_ev) begin
        busy_q <= 1'b0;
        rx_q <= link_rx; // R10
      end
    end
  end
  // ----------------------------------------
  // per group pins
  // ----------------------------------------
  // ack is registered after the synchronisers, so it trails the pins by three
  // edges; irq is registered straight from IRQ_PENDING_I; hosts must not rely on a faster ack
  logic [NGRP-1:0] irq_oe_n_q;
  logic [NGRP-1:0] ack_oe_n_q;
  assign IRQ_OE_N_O = irq_oe_n_q;
  assign XFER_ACK_OE_N_O = ack_oe_n_q;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_oe_n_q <= '1;
      ack_oe_n_q <= '1;
    end else begin
      irq_oe_n_q <= ~IRQ_PENDING_I; // R6 R7
      ack_oe_n_q <= cs_s | {NGRP{as_s}}; // R8 R9
    end
  end
  // output tick stays high for the first half of each interval
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    logic [CW-1:0] cnt_q;
    logic tick_d1_q;
    logic pulse_q;
    logic out_q;
    wire logic align = ~tick_out & tick_s[g] & ~tick_d1_q; // R4
    wire logic wrap = (cnt_q == CW'(SEC_CYCLES - 1));
    wire logic [CW-1:0] cnt_d = (align | wrap) ? '0 : cnt_q + CW'(1);
    assign STATUS_TICK_O[g] = pulse_q;
    assign SECOND_TICK_O[g] = out_q;
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        cnt_q <= '0;
        tick_d1_q <= 1'b0;
        pulse_q <= 1'b0;
        out_q <= 1'b0;
      end else begin
        tick_d1_q <= tick_s[g];
        cnt_q <= cnt_d; // R4 R9
        pulse_q <= align | wrap;
        out_q <= tick_out & (cnt_d < CW'(SEC_CYCLES / 2)); // R5
      end
    end
  end
  // ----------------------------------------
  // line serial master
  // ----------------------------------------
  hplsm_ser_link #(
    .HALF_FAST(SER_HALF_FAST),
    .HALF_SLOW(SER_HALF_SLOW)
  ) u_link (
    .link_clk_i(LINK_CLK_I),
    .rst_n_i(RESETN_I),
    .start_tgl_i(start_tgl_q),
    .cfg_i(ser_cfg),
    .word_i(word_q),
    .done_tgl_o(link_done_tgl),
    .rx_o(link_rx),
    .ser_in_i(LINE_SER_IN_I),
    .ser_clk_o(LINE_SER_CLK_O),
    .ser_out_o(LINE_SER_OUT_O),
    .sel_n_o(LINE_SER_SELECT_N_O)
  );
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  a_float_deselect: assert property (!cs_any |=> HOST_AD_OE_N_O) // R1
    else $error("data bus driven without chip select");
  a_read_strobe: assert property (style_s && cs_any && !strobe_s |=> !HOST_AD_OE_N_O) // R2
    else $error("read strobe did not drive data bus");
  a_write_strobe: assert property (REG_WR_O && $past(style_s) |-> $past(!dir_s)) // R3
    else $error("write taken without write strobe");
  a_addr_latch: assert property ($fell(as_s) |=> REG_ADDR_O == $past(addr_mux)) // R18
    else $error("address not latched on strobe fall");
  a_ack_assert: assert property (!as_s && !cs_s[0] |=> !XFER_ACK_OE_N_O[0]) // R8
    else $error("transfer ack not pulled low");
  a_ack_release: assert property (as_s |=> XFER_ACK_OE_N_O[0] && XFER_ACK_OE_N_O[NGRP-1]) // R8
    else $error("transfer ack held after strobe release");
  a_irq_pull: assert property (IRQ_PENDING_I[0] |=> !IRQ_OE_N_O[0]) // R6
    else $error("irq not pulled with request pending");
  a_irq_release: assert property (!IRQ_PENDING_I[NGRP-1] |=> IRQ_OE_N_O[NGRP-1]) // R7
    else $error("irq held after requests serviced");
  a_tick_rise: assert property (tick_out && STATUS_TICK_O[0] |-> $rose(SECOND_TICK_O[0])) // R5
    else $error("tick pin did not rise at interval start");
  // sync mode keeps the same sampling; this guards that it really does
  a_sync_sample: assert property (syncm_s && style_s && cs_any && !strobe_s |=> rd_act_q) // R19
    else $error("synchronous mode strobe not sampled on clock");
  a_read_drive: assert property (rd_act |=> !HOST_AD_OE_N_O) // R2
    else $error("active read did not drive data bus");
  a_commit_once: assert property (REG_WR_O |=> !REG_WR_O) // R3
    else $error("write committed twice");
  a_muxed_addr: assert property ($fell(as_s) && style_s |=> REG_ADDR_O[7:0] == $past(ad_s)) // R17
    else $error("muxed low address not taken from data bus");
  a_split_addr: assert property ($fell(as_s) && !style_s |=> REG_ADDR_O == $past(a_s)) // R17
    else $error("separate address not taken from address pins");
  a_ack_upper: assert property (!as_s && !cs_s[NGRP-1] |=> !XFER_ACK_OE_N_O[NGRP-1]) // R9
    else $error("upper group ack not pulled low");
  a_irq_upper: assert property (IRQ_PENDING_I[NGRP-1] |=> !IRQ_OE_N_O[NGRP-1]) // R9
    else $error("upper group irq not pulled low");
  a_align_restart: assert property ( // R4
    !tick_out && tick_s[0] && !$past(tick_s[0]) |=> STATUS_TICK_O[0])
    else $error("input tick edge did not restart interval");
endmodule : hplsm_host_port
`default_nettype wire

// ---- hplsm_liu_model.sv ----
// line interface unit serial port model for the line serial master bench
// assumes active-low selects and a serial clock that idles low
`default_nettype none
module hplsm_liu_model (
  input wire logic ser_clk_i,
  input wire logic ser_out_i,
  input wire logic [1:0] sel_n_i,
  input wire logic [7:0] resp_i,
  output var logic ser_in_o,
  output var logic [15:0] word_o,
  output var logic [1:0] sel_o,
  output var int bits_o,
  output var int viol_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic act;
  assign act = ~&sel_n_i;
  initial begin
    ser_in_o = 1'b0;
    word_o = '0;
    sel_o = 2'b11;
    bits_o = 0;
    viol_o = 0;
  end
  // ----
  // frame capture
  // ----
  always @(posedge act) begin
    bits_o = 0;
    sel_o = sel_n_i;
  end
  // reply bit goes out right after a rise so it is settled a full period later
  always @(posedge ser_clk_i) begin
    if (act) begin
      word_o = {word_o[14:0], ser_out_i};
      bits_o++;
      ser_in_o = (bits_o >= 8 && bits_o < 16) ? resp_i[15 - bits_o] : ~ser_in_o;
    end
  end
  always @(ser_out_i) begin
    if (act) begin
      #0.1;
      if (ser_clk_i) viol_o++;
    end
  end
  // released line shows the inverse, not the last bit
  always @(negedge act) begin
    if (bits_o != 16) viol_o++;
    ser_in_o = ~ser_in_o;
  end
endmodule : hplsm_liu_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the host port and line serial master
// assumes the package, the design and the line unit model compile first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, lclk, rst_n, bs, sy, as_n, stb_n, dir, wr, oe_n, sin, sclk, sout, tprev;
  logic [1:0] g, cs_n, irq, tk_i, irq_oe, ack_oe, tk_o, tk_oe, st, ssel, msel, irq_o, ack_o;
  logic [11:0] a, ra, wa;
  logic [7:0] ad, ad_o, rdat, rw, wd, q, resp;
  logic [15:0] mword;
  int fails = 0, samples_checked = 0, cyc = 0, l0 = 0, per0 = 0, np = 0, nr = 0, wn = 0;
  int mbits, mviol;
  realtime tr = 0, per = 0;
  wire logic [7:0] ad_w = oe_n ? ad : ad_o;
  wire logic [1:0] tk_w = (tk_oe & tk_i) | (~tk_oe & tk_o);
  hplsm_host_port #(.NGRP(2), .SEC_CYCLES(200), .SER_HALF_FAST(2), .SER_HALF_SLOW(4))
  i_hplsm_host_port (
    .MCLK_I(clk), .RESETN_I(rst_n), .LINK_CLK_I(lclk), .BUS_STYLE_SELECT_I(bs),
    .SYNC_BUS_SELECT_I(sy), .HOST_SELECT_N_I(cs_n), .HOST_ADDR_LATCH_N_I(as_n),
    .HOST_STROBE_N_I(stb_n), .HOST_DIR_I(dir), .HOST_ADDR_I(a), .HOST_AD_I(ad_w),
    .HOST_AD_O(ad_o), .HOST_AD_OE_N_O(oe_n), .REG_ADDR_O(ra), .REG_WDATA_O(rw),
    .REG_WR_O(wr), .REG_RDATA_I(rdat), .IRQ_PENDING_I(irq), .IRQ_N_O(irq_o),
    .IRQ_OE_N_O(irq_oe), .XFER_ACK_N_O(ack_o), .XFER_ACK_OE_N_O(ack_oe), .SECOND_TICK_I(tk_w),
    .SECOND_TICK_O(tk_o), .SECOND_TICK_OE_N_O(tk_oe), .STATUS_TICK_O(st),
    .LINE_SER_IN_I(sin), .LINE_SER_CLK_O(sclk), .LINE_SER_OUT_O(sout),
    .LINE_SER_SELECT_N_O(ssel));
  hplsm_liu_model i_hplsm_liu_model (
    .ser_clk_i(sclk), .ser_out_i(sout), .sel_n_i(ssel), .resp_i(resp),
    .ser_in_o(sin), .word_o(mword), .sel_o(msel), .bits_o(mbits), .viol_o(mviol));
  // ----
  // clocks and monitors
  // ----
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 0;
    #1.3;
    forever #3 lclk = ~lclk;
  end
  always @(posedge sclk) begin
    per = $realtime - tr;
    tr = $realtime;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tprev <= tk_o[0];
    if (wr === 1'b1) begin
      wa <= ra;
      wd <= rw;
    end
    if (st[0] === 1'b1) begin
      per0 <= cyc - l0;
      l0 <= cyc;
      np <= np + 1;
    end
    if (tk_o[0] === 1'b1 && tprev === 1'b0) nr <= nr + 1;
  end
  // ----
  // tasks
  // ----
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task test_done;
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // one host access; address strobe stays low so the acknowledge can be seen
  task acc(input logic w, input logic [11:0] aa, input logic [7:0] d);
    @(negedge clk);
    a = bs ? {aa[11:8], 8'h00} : aa;
    ad = bs ? aa[7:0] : d;
    as_n = 0;
    repeat (5) @(negedge clk);
    ad = d;
    cs_n = g;
    stb_n = bs & w;
    dir = ~w;
    repeat (6) @(negedge clk);
    q = ad_o;
    chk(ack_oe, g);
    chk(oe_n, w);
    stb_n = 1;
    dir = 1;
    cs_n = 2'b11;
    as_n = 1;
    repeat (6) @(negedge clk);
    chk({oe_n, ack_oe}, 3'h7);
  endtask : acc
  task wp;
    wn = 0;
    @(negedge clk);
    while (st[0] !== 1'b1 && wn < 300) begin
      @(negedge clk);
      wn++;
    end
  endtask : wp
  task ser(input logic [7:0] c, input logic [7:0] sa, input logic [7:0] sd);
    int n;
    n = 0;
    acc(1, 12'h025, c);
    acc(1, 12'h023, sd);
    acc(1, 12'h024, sa);
    do begin
      acc(0, 12'h025, 8'h00);
      n++;
    end while (q[7] !== 1'b0 && n < 30);
    chk(mword, {sa, sd});
    chk({msel, mbits[7:0]}, {~c[1:0], 8'h10});
    chk(int'(per), c[2] ? 24 : 48);
    acc(0, 12'h023, 8'h00);
    chk(q, resp);
  endtask : ser
  // ----
  // tests
  // ----
  initial begin
    {bs, sy, as_n, stb_n, dir, rst_n} = 6'b001110;
    {g, cs_n, irq, tk_i} = 8'b10110000;
    a = '0;
    ad = '0;
    rdat = '0;
    resp = '0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    chk({oe_n, tk_oe, ssel, irq_oe, ack_oe}, 9'h1FF);
    chk({irq_o, ack_o}, 4'h0);
    acc(0, 12'h025, 8'h00);
    chk(q, 8'h00);
    acc(1, 12'h025, 8'h05);
    acc(0, 12'h025, 8'h00);
    chk(q, 8'h05);
    acc(1, 12'h100, 8'h5A);
    chk({wa, wd}, {12'h100, 8'h5A});
    rdat = 8'hC3;
    acc(0, 12'h0F1, 8'h00);
    chk({ra, q}, {12'h0F1, 8'hC3});
    bs = 1;
    sy = 1;
    g = 2'b01;
    acc(1, 12'h234, 8'hA7);
    chk({wa, wd}, {12'h234, 8'hA7});
    rdat = 8'h96;
    acc(0, 12'h345, 8'h00);
    chk({ra, q}, {12'h345, 8'h96});
    bs = 0;
    g = 2'b10;
    irq = 2'b10;
    repeat (4) @(negedge clk);
    chk(irq_oe, 2'b01);
    irq = 2'b00;
    repeat (4) @(negedge clk);
    chk(irq_oe, 2'b11);
    acc(1, 12'h025, 8'h08);
    chk(tk_oe, 2'b00);
    wp;
    {np, nr} = '0;
    repeat (400) @(posedge clk);
    wp;
    @(negedge clk);
    chk({np[3:0], nr[3:0]}, 8'h33);
    chk(per0, 200);
    acc(1, 12'h025, 8'h00);
    chk(tk_oe, 2'b11);
    wp;
    repeat (50) @(negedge clk);
    tk_i = 2'b11;
    wp;
    chk(wn < 7, 1);
    tk_i = 2'b00;
    wp;
    @(negedge clk);
    chk(per0, 200);
    resp = 8'h69;
    ser(8'h05, 8'h81, 8'h3C);
    resp = 8'hB4;
    ser(8'h02, 8'h7E, 8'hC5);
    chk(mviol, 0);
    test_done;
  end
  initial begin
    #400000;
    fails++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
